// ---- hw/bb_cfg_pkg.sv ----
// Constants, field layouts and types for the baseband configuration block.
// Assumes a 10 MHz device clock and a byte-wide serial register port.
package bb_cfg_pkg;

  localparam int unsigned CLK_HZ = 10000000;

  // Register offsets (6-bit address space)
  localparam logic [5:0] RATE_OFS = 6'h04;
  localparam logic [5:0] IRQP_OFS = 6'h05;

  // Field positions in the rate register
  localparam int unsigned CODE_W_BIT = 2;
  localparam int unsigned DRATE_BIT  = 1;
  localparam int unsigned SRATE_BIT  = 0;

  // Reset values
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [1:0] IRQP_RST = 2'h1;

  // Serial command byte layout
  localparam int unsigned CMD_WR_BIT  = 7;
  localparam int unsigned CMD_INC_BIT = 6;

  // Pin drive styles
  localparam logic [1:0] IRQ_OPEN_SRC = 2'h3;
  localparam logic [1:0] IRQ_OPEN_DRN = 2'h2;
  localparam logic [1:0] IRQ_CMOS     = 2'h1;
  localparam logic [1:0] IRQ_CMOS_INV = 2'h0;

  // Raw bit times: 62.5 kbit/s double rate, 32 kbit/s normal rate
  localparam int unsigned BIT_NS_DOUBLE = 16000;
  localparam int unsigned BIT_NS_NORMAL = 31250;
  localparam longint unsigned NS_PER_S  = 64'd1000000000;
  // Longest time: round down
  localparam int unsigned BIT_CYC_DOUBLE =
    int'((longint'(BIT_NS_DOUBLE) * CLK_HZ) / NS_PER_S);
  localparam int unsigned BIT_CYC_NORMAL =
    int'((longint'(BIT_NS_NORMAL) * CLK_HZ) / NS_PER_S);
  localparam int unsigned BIT_CNT_W = 9;

  typedef struct packed {
    logic code_32;
    logic double_rate;
    logic sample_12x;
  } rate_cfg_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD  = 2'b01,
    SPI_DATA = 2'b10
  } spi_state_t;

endpackage

// ---- hw/bb_rate_cfg.sv ----
// Baseband rate and interrupt-pin configuration with its serial register port.
// Assumes serial pins synchronous to i_mclk, clock idle low, at most 2 MHz.
//
// Overview of operation
// RQ1: Bit 2 of rate register set means 32-chip codes, clear means 64-chip.
// RQ2: Bit 1 set means two data bits per code, clear means one.
// RQ3: Double rate acts only with 32-chip codes; 64-chip is one bit per code.
// RQ4: Double rate splits the stored 64-chip code into two 32-chip halves.
// RQ5: Raw throughput 62.5 kbit/s double rate, 32 kbit/s normal rate.
// RQ6: Normal rate with 32-chip codes allows correlating against two codes.
// RQ7: Bit 0 set means twelve-times oversampling, clear means six-times.
// RQ8: Twelve-times applies only to 32-chip normal rate, else bit ignored.
// RQ9: Host never writes rate patterns 001, 010, 011 or 111.
// RQ10: Host writes zeros to unused upper bits of both registers.
// RQ11: Pin select 11 drives high when asserted, 10 drives low; else released.
// RQ12: Pin select 01 drives high/low actively, 00 drives low/high actively.
// RQ13: With 32-chip codes, code select picks upper or lower half.
// RQ14: Reset loads rate register with zero and pin register with one.
`timescale 1ns/1ps

module bb_rate_cfg (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_spi_ss_n,
  input  wire logic i_spi_sck,
  input  wire logic i_spi_mosi,
  output logic      o_spi_miso,
  output logic      o_spi_miso_oe,
  input  wire logic i_irq_req,
  output logic      o_irq_out,
  output logic      o_irq_oe,
  input  wire logic i_code_sel_upper,
  output logic      o_chips_32,
  output logic      o_double_rate,
  output logic      o_sample_12x,
  output logic      o_split_code,
  output logic      o_dual_corr,
  output logic      o_code_half_upper,
  output logic      o_bit_strobe
);

  localparam int unsigned BW = bb_cfg_pkg::BIT_CNT_W;

  // Serial port state
  bb_cfg_pkg::spi_state_t st_q, st_d;
  logic       sck_q, sck_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [5:0] addr_q, addr_d;
  logic       wr_q, wr_d;
  logic       inc_q, inc_d;
  logic       miso_q, miso_d;
  logic       miso_oe_q, miso_oe_d;

  // Register contents; reserved bits are not stored and read as zero
  bb_cfg_pkg::rate_cfg_t rate_q, rate_d;
  logic [1:0]            irqp_q, irqp_d;

  // Mode outputs
  bb_cfg_pkg::rate_cfg_t eff_q, eff_d;
  logic                  split_q, split_d;
  logic                  dual_q, dual_d;
  logic                  half_q, half_d;

  // Bit timer
  logic [BW-1:0]         bcnt_q, bcnt_d;
  logic                  strobe_q, strobe_d;

  // Pin drive
  logic                  irq_out_q, irq_out_d;
  logic                  irq_oe_q, irq_oe_d;

  // Unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input logic [5:0] a,
                                          input bb_cfg_pkg::rate_cfg_t r,
                                          input logic [1:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (a == bb_cfg_pkg::RATE_OFS) begin
      v = {5'h00, r};
    end else if (a == bb_cfg_pkg::IRQP_OFS) begin
      v = {6'h00, p};
    end
    return v;
  endfunction

  // Rising serial clock that completes a byte
  function automatic logic byte_done(input logic rise, input logic [2:0] cnt);
    return rise && (cnt == 3'h7);
  endfunction

  // Last count of one raw bit time at the current rate
  function automatic logic [BW-1:0] bit_last(input logic dbl);
    logic [BW-1:0] v;
    v = BW'(bb_cfg_pkg::BIT_CYC_NORMAL - 1);
    if (dbl) begin
      v = BW'(bb_cfg_pkg::BIT_CYC_DOUBLE - 1);
    end
    return v;
  endfunction

  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] byte_in;

  // Clock idles low, so the zero reset of its sample gives no false edge
  assign sck_rise = i_spi_sck & ~sck_q;
  assign sck_fall = ~i_spi_sck & sck_q;
  assign byte_in  = {sh_q[6:0], i_spi_mosi};

  // Serial register port: command byte {write, increment, address[5:0]} then data
  always_comb begin
    st_d      = st_q;
    sck_d     = i_spi_sck;
    bit_d     = bit_q;
    sh_d      = sh_q;
    tx_d      = tx_q;
    addr_d    = addr_q;
    wr_d      = wr_q;
    inc_d     = inc_q;
    miso_d    = miso_q;
    miso_oe_d = 1'b0;
    rate_d    = rate_q;
    irqp_d    = irqp_q;
    // Deselect drops a partial byte; stored registers keep their value
    if (i_spi_ss_n) begin
      st_d  = bb_cfg_pkg::SPI_IDLE;
      bit_d = 3'h0;
    end else begin
      case (st_q)
        bb_cfg_pkg::SPI_IDLE: begin
          // A rise in the select cycle is already the first command bit
          st_d  = bb_cfg_pkg::SPI_CMD;
          bit_d = 3'h0;
          if (sck_rise) begin
            sh_d  = byte_in;
            bit_d = 3'h1;
          end
        end
        bb_cfg_pkg::SPI_CMD: begin
          if (sck_rise) begin
            sh_d  = byte_in;
            bit_d = bit_q + 3'h1;
            if (byte_done(sck_rise, bit_q)) begin
              st_d   = bb_cfg_pkg::SPI_DATA;
              wr_d   = byte_in[bb_cfg_pkg::CMD_WR_BIT];
              inc_d  = byte_in[bb_cfg_pkg::CMD_INC_BIT];
              addr_d = byte_in[5:0];
              tx_d   = read_reg(byte_in[5:0], rate_q, irqp_q);
            end
          end
        end
        bb_cfg_pkg::SPI_DATA: begin
          miso_oe_d = ~wr_q;
          // Output bit moves on the falling edge and stands through the next rise
          if (sck_fall) begin
            miso_d = tx_q[3'h7 - bit_q];
          end
          if (sck_rise) begin
            sh_d  = byte_in;
            bit_d = bit_q + 3'h1;
            if (byte_done(sck_rise, bit_q)) begin
              if (wr_q && addr_q == bb_cfg_pkg::RATE_OFS) begin
                rate_d = byte_in[2:0];  // [RQ1] [RQ2] [RQ7] [RQ10]
              end else if (wr_q && addr_q == bb_cfg_pkg::IRQP_OFS) begin
                irqp_d = byte_in[1:0];  // [RQ10]
              end
              // Reload from next values so a burst read sees its own write
              if (inc_q) begin
                addr_d = addr_q + 6'h01;
                tx_d   = read_reg(addr_q + 6'h01, rate_d, irqp_d);
              end else begin
                tx_d   = read_reg(addr_q, rate_d, irqp_d);
              end
            end
          end
        end
        default: begin
          st_d = bb_cfg_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  // Register file shares this group with the serial engine it is written from
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q      <= bb_cfg_pkg::SPI_IDLE;
      sck_q     <= 1'b0;
      bit_q     <= 3'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      addr_q    <= 6'h00;
      wr_q      <= 1'b0;
      inc_q     <= 1'b0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
      rate_q    <= bb_cfg_pkg::RATE_RST;  // [RQ14]
      irqp_q    <= bb_cfg_pkg::IRQP_RST;  // [RQ14]
    end else begin
      st_q      <= st_d;
      sck_q     <= sck_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      tx_q      <= tx_d;
      addr_q    <= addr_d;
      wr_q      <= wr_d;
      inc_q     <= inc_d;
      miso_q    <= miso_d;
      miso_oe_q <= miso_oe_d;
      rate_q    <= rate_d;
      irqp_q    <= irqp_d;
    end
  end

  // Effective mode; forbidden patterns are not trapped, only masked by the
  // gating below, since the host is trusted to avoid them [RQ9]
  always_comb begin
    eff_d.code_32     = rate_q.code_32;                                 // [RQ1]
    eff_d.double_rate = rate_q.code_32 & rate_q.double_rate;            // [RQ2] [RQ3]
    eff_d.sample_12x  = rate_q.code_32 & ~rate_q.double_rate
                        & rate_q.sample_12x;                            // [RQ7] [RQ8]
    split_d = eff_d.double_rate;                                        // [RQ4]
    dual_d  = rate_q.code_32 & ~rate_q.double_rate;                     // [RQ6]
    half_d  = rate_q.code_32 & i_code_sel_upper;                        // [RQ13]
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eff_q   <= '0;
      split_q <= 1'b0;
      dual_q  <= 1'b0;
      half_q  <= 1'b0;
    end else begin
      eff_q   <= eff_d;
      split_q <= split_d;
      dual_q  <= dual_d;
      half_q  <= half_d;
    end
  end

  // Free-running bit timer; the period in flight at a rate change is irregular
  always_comb begin
    bcnt_d   = (bcnt_q >= bit_last(eff_q.double_rate)) ? '0 : bcnt_q + 1'b1;
    strobe_d = (bcnt_d == '0);                                          // [RQ5]
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bcnt_q   <= '0;
      strobe_q <= 1'b0;
    end else begin
      bcnt_q   <= bcnt_d;
      strobe_q <= strobe_d;
    end
  end

  // Pin drive; the released level is set by the board's pull resistor
  always_comb begin
    case (irqp_q)
      bb_cfg_pkg::IRQ_OPEN_SRC: begin
        irq_out_d = 1'b1;                                               // [RQ11]
        irq_oe_d  = i_irq_req;
      end
      bb_cfg_pkg::IRQ_OPEN_DRN: begin
        irq_out_d = 1'b0;                                               // [RQ11]
        irq_oe_d  = i_irq_req;
      end
      bb_cfg_pkg::IRQ_CMOS: begin
        irq_out_d = i_irq_req;                                          // [RQ12]
        irq_oe_d  = 1'b1;
      end
      default: begin
        irq_out_d = ~i_irq_req;                                         // [RQ12]
        irq_oe_d  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_out_q <= 1'b0;
      irq_oe_q  <= 1'b1;
    end else begin
      irq_out_q <= irq_out_d;
      irq_oe_q  <= irq_oe_d;
    end
  end

  assign o_spi_miso        = miso_q;
  assign o_spi_miso_oe     = miso_oe_q;
  assign o_irq_out         = irq_out_q;
  assign o_irq_oe          = irq_oe_q;
  assign o_chips_32        = eff_q.code_32;
  assign o_double_rate     = eff_q.double_rate;
  assign o_sample_12x      = eff_q.sample_12x;
  assign o_split_code      = split_q;
  assign o_dual_corr       = dual_q;
  assign o_code_half_upper = half_q;
  assign o_bit_strobe      = strobe_q;

endmodule

// ---- sim/bb_rate_cfg_chk.sv ----
// Port-level checker for the rate and pin configuration block.
// Assumes one clock domain; bound to the design after the module.
`timescale 1ns/1ps
module bb_rate_cfg_chk (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_irq_req,
  input wire logic o_irq_out,
  input wire logic o_irq_oe,
  input wire logic o_chips_32,
  input wire logic o_double_rate,
  input wire logic o_sample_12x,
  input wire logic o_split_code,
  input wire logic o_dual_corr,
  input wire logic o_bit_strobe
);
  logic [8:0] gap_q, gap_d;
  logic       seen_q, seen_d, chg_q, chg_d, dr_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  always_comb begin
    gap_d  = o_bit_strobe ? 9'h000 : gap_q + 9'h001;
    seen_d = seen_q | o_bit_strobe;
    // Periods straddling a rate change are not judged
    chg_d  = o_bit_strobe ? 1'b0 : (chg_q | (o_double_rate != dr_q));
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_q  <= 9'h000;
      seen_q <= 1'b0;
      chg_q  <= 1'b0;
      dr_q   <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
      chg_q  <= chg_d;
      dr_q   <= o_double_rate;
    end
  end
  sequence quiet_s;
    !o_bit_strobe [*8];
  endsequence
  dbl_needs32_a: assert property (o_double_rate |-> o_chips_32)
    else $error("double rate without 32 chips");
  s12_gate_a: assert property (o_sample_12x |-> o_chips_32 && !o_double_rate)
    else $error("12x outside 32 chip normal rate");
  split_code_a: assert property (o_split_code == o_double_rate)
    else $error("split differs from double rate");
  dual_corr_a: assert property (o_dual_corr == (o_chips_32 && !o_double_rate))
    else $error("dual correlation wrong");
  pin_release_a: assert property (!o_irq_oe |-> !$past(i_irq_req))
    else $error("pin released while asserted");
  bit_period_a: assert property (o_bit_strobe && seen_q && !chg_q && o_double_rate == dr_q
    |-> gap_q == (o_double_rate ? 9'h09f : 9'h137))
    else $error("bit time wrong");
  strobe_pulse_a: assert property (o_bit_strobe |=> quiet_s)
    else $error("strobe too close");
  reset_vals_a: assert property ($rose(i_arst_n) |-> o_irq_oe && !o_irq_out
    && !o_chips_32 && !o_double_rate && !o_sample_12x)
    else $error("reset outputs wrong");
endmodule
bind bb_rate_cfg bb_rate_cfg_chk u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_irq_req(i_irq_req), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
  .o_chips_32(o_chips_32), .o_double_rate(o_double_rate), .o_sample_12x(o_sample_12x),
  .o_split_code(o_split_code), .o_dual_corr(o_dual_corr), .o_bit_strobe(o_bit_strobe));

// ---- sim/spi_host_model.sv ----
// Host model: mode 0 serial master, command byte then one data byte.
// Assumes the device samples the serial pins with the same clock.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_mclk,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  output logic      o_ss_n,
  output logic      o_sck,
  output logic      o_mosi
);
  initial begin
    o_ss_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    @(posedge i_mclk) o_ss_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_mclk) begin
        o_sck  <= 1'b0;
        o_mosi <= sh[i];
      end
      @(posedge i_mclk);
      @(posedge i_mclk);
      // Undriven line reads unknown, so a missing answer never matches
      @(posedge i_mclk) begin
        o_sck <= 1'b1;
        rd[i%8] = i_miso_oe ? i_miso : 1'bx;
      end
      @(posedge i_mclk);
    end
    @(posedge i_mclk) o_sck <= 1'b0;
    @(posedge i_mclk) begin
      o_ss_n <= 1'b1;
      o_mosi <= ~o_mosi;
    end
    @(posedge i_mclk);
  endtask
endmodule

// ---- sim/baseband_rate_irq_config_bench.sv ----
// Self-checking bench for the rate and pin configuration block.
// Assumes the host model drives the serial port; the checker is bound.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module baseband_rate_irq_config_bench;
  logic i_mclk, i_arst_n, i_irq_req, i_code_sel_upper;
  logic ss_n, sck, mosi, miso, miso_oe, irq_out, irq_oe;
  logic chips, dbl, s12, split, dual, half, strobe;
  int   n_mismatch = 0;
  int   check_count = 0;
  bb_rate_cfg dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_spi_ss_n(ss_n),
    .i_spi_sck(sck), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .i_irq_req(i_irq_req), .o_irq_out(irq_out), .o_irq_oe(irq_oe),
    .i_code_sel_upper(i_code_sel_upper), .o_chips_32(chips), .o_double_rate(dbl),
    .o_sample_12x(s12), .o_split_code(split), .o_dual_corr(dual),
    .o_code_half_upper(half), .o_bit_strobe(strobe));
  spi_host_model host (.i_mclk(i_mclk), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_ss_n(ss_n), .o_sck(sck), .o_mosi(mosi));
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer({2'b10, a}, d, x);
  endtask
  task automatic settle;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 400);
    if (strobe !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic t_reset;
    logic [7:0] d;
    `CHK("mode outs", 5'h00, {chips, dbl, s12, dual, half})
    host.xfer({2'b00, bb_cfg_pkg::RATE_OFS}, 8'h00, d);
    `CHK("rate reg", 8'h00, d)
    host.xfer({2'b00, bb_cfg_pkg::IRQP_OFS}, 8'h00, d);
    `CHK("pin reg", 8'h01, d)
    host.xfer(8'h06, 8'h00, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_rate;
    logic [2:0] pat [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
    logic [7:0] d;
    logic       c, r;
    foreach (pat[i]) begin
      c = pat[i][2];
      r = pat[i][1];
      wr(bb_cfg_pkg::RATE_OFS, {5'h00, pat[i]});
      `CHK("chips 32", c, chips)
      `CHK("double", c & r, dbl)
      `CHK("split", c & r, split)
      `CHK("dual corr", c & ~r, dual)
      `CHK("sample 12x", c & ~r & pat[i][0], s12)
      @(posedge i_mclk) i_code_sel_upper <= 1'b1;
      settle();
      `CHK("upper half", c, half)
      @(posedge i_mclk) i_code_sel_upper <= 1'b0;
      host.xfer({2'b00, bb_cfg_pkg::RATE_OFS}, 8'h00, d);
      `CHK("rate back", {5'h00, pat[i]}, d)
      `CHK("lower half", 1'b0, half)
    end
  endtask
  task automatic t_irq;
    logic [1:0] m;
    for (int k = 0; k < 8; k++) begin
      m = k[2:1];
      if (k[0] == 1'b0) wr(bb_cfg_pkg::IRQP_OFS, {6'h00, m});
      @(posedge i_mclk) i_irq_req <= k[0];
      settle();
      `CHK("pin oe", m[1] ? k[0] : 1'b1, irq_oe)
      `CHK("pin out", m[1] ? m[0] : ~(k[0] ^ m[0]), irq_out)
    end
    @(posedge i_mclk) i_irq_req <= 1'b0;
  endtask
  task automatic t_strobe;
    int n;
    wr(bb_cfg_pkg::RATE_OFS, 8'h06);
    wait_strobe(n);
    wait_strobe(n);
    `CHK("double bit", 160, n)
    wr(bb_cfg_pkg::RATE_OFS, 8'h04);
    wait_strobe(n);
    wait_strobe(n);
    `CHK("normal bit", 312, n)
  endtask
  task automatic t_rearm;
    @(posedge i_mclk) i_arst_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    t_reset();
  endtask
  initial begin
    i_arst_n = 1'b0;
    i_irq_req = 1'b0;
    i_code_sel_upper = 1'b0;
    repeat (20) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    t_reset();
    t_rate();
    t_irq();
    t_strobe();
    t_rearm();
    complete_run();
  end
endmodule
